// >>> hdl/solc_defines.svh
// Register offsets, field positions, reset values for the section/line bank
`ifndef SOLC_DEFINES_SVH
`define SOLC_DEFINES_SVH
`define SOLC_ADDR_W 8
`define SOLC_OFF_CLK_RECOVERY 8'h09
`define SOLC_OFF_TX_CFG1 8'h0a
`define SOLC_OFF_TX_CFG2 8'h0b
`define SOLC_OFF_RX_CFG 8'h0c
`define SOLC_OFF_SEC_CTRL 8'h10
`define SOLC_OFF_SEC_STAT 8'h11
`define SOLC_RST_CLK_RECOVERY 8'h07
`define SOLC_MASK_CLK_RECOVERY 8'h07
`define SOLC_RST_TX_CFG1 8'h2c
`define SOLC_MASK_TX_CFG1 8'hbf
`define SOLC_RST_TX_CFG2 8'hff
`define SOLC_RST_RX_CFG 8'h01
`define SOLC_MASK_RX_CFG 8'h7f
`define SOLC_RST_SEC_CTRL 8'h00
`define SOLC_MASK_SEC_CTRL 8'hdf
// Control bit positions
`define SOLC_B_OOF_EN 0
`define SOLC_B_LOF_EN 1
`define SOLC_B_LOS_EN 2
`define SOLC_B_BIP_EN 3
`define SOLC_B_FORCE 5
`define SOLC_B_DDS 6
// Transmitter configuration bit positions
`define SOLC_B_TQ 4
`define SOLC_B_OE 5
`define SOLC_B_VREF 7
`endif

// >>> hdl/solc_pkg.sv
// Types shared by the section/line register bank
package solc_pkg;
  typedef struct packed {
    logic [7:0] clkRec;
    logic [7:0] txCfg1;
    logic [7:0] txCfg2;
    logic [7:0] rxCfg;
    logic [7:0] secCtrl;
    logic [2:0] stateSeen;
    logic [3:0] events;
    logic [7:0] rdData;
    logic forceReq;
    logic irq;
  } solc_state_t;
endpackage

// >>> hdl/section_overhead_line_config_regs.sv
// Section overhead and line interface control/status register bank
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/10ps
`include "solc_defines.svh"

module section_overhead_line_config_regs
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  input wire logic frameOutState,
  input wire logic frameLossState,
  input wire logic signalLossState,
  input wire logic sectionParityErr,
  input wire logic frameBoundary,
  output logic forceFrameLoss,
  output logic descrambleDisable,
  output logic txDriveEnable,
  output logic txTrueQuiet,
  output logic referenceSelect,
  output logic [7:0] clockRecoveryCfg,
  output logic [7:0] txCfgSecond,
  output logic [7:0] rxCfg,
  output logic irqOut
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  solc_pkg::solc_state_t state_r;
  solc_pkg::solc_state_t state_nxt;
  logic [2:0] stateNow;
  logic [3:0] eventHits;
  logic [3:0] eventEnables;
  logic [7:0] statusWord;

  // Packs the four enables out of the control word
  function automatic logic [3:0] enablesOf(input logic [7:0] ctrl);
    enablesOf = ctrl[3:0];
  endfunction

  // Detector levels come from same-clock framer logic, so no sync stages
  assign stateNow = {signalLossState, frameLossState, frameOutState};
  assign eventEnables = enablesOf(state_r.secCtrl);
  // A change in any alarm state, or a parity error, is an event
  assign eventHits = {sectionParityErr, stateNow ^ state_r.stateSeen};
  // Live state in low bits, latched events above, bit 7 unused
  assign statusWord = {1'b0, state_r.events, stateNow};

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  // Register writes, read mux, event latching and interrupt combine
  always_comb
  begin
    state_nxt = state_r;
    state_nxt.stateSeen = stateNow;
    state_nxt.rdData = 8'h00;
    // Boundary drops a pending request; a force write in the same
    // cycle re-arms it, so that write is never lost
    if (state_r.forceReq && frameBoundary)
      state_nxt.forceReq = 1'b0;
    if (regWrite)
    begin
      case (regAddr)
        `SOLC_OFF_CLK_RECOVERY:
          state_nxt.clkRec = regWrData & `SOLC_MASK_CLK_RECOVERY;
        `SOLC_OFF_TX_CFG1:
          state_nxt.txCfg1 = regWrData & `SOLC_MASK_TX_CFG1;
        `SOLC_OFF_TX_CFG2:
          state_nxt.txCfg2 = regWrData;
        `SOLC_OFF_RX_CFG:
          state_nxt.rxCfg = regWrData & `SOLC_MASK_RX_CFG;
        `SOLC_OFF_SEC_CTRL:
        begin
          // Force bit is not stored; it arms a request instead
          state_nxt.secCtrl = regWrData & `SOLC_MASK_SEC_CTRL;
          if (regWrData[`SOLC_B_FORCE])
            state_nxt.forceReq = 1'b1;
        end
        default:
          state_nxt.clkRec = state_r.clkRec;
      endcase
    end
    if (regRead)
    begin
      case (regAddr)
        `SOLC_OFF_CLK_RECOVERY: state_nxt.rdData = state_r.clkRec;
        `SOLC_OFF_TX_CFG1: state_nxt.rdData = state_r.txCfg1;
        `SOLC_OFF_TX_CFG2: state_nxt.rdData = state_r.txCfg2;
        `SOLC_OFF_RX_CFG: state_nxt.rdData = state_r.rxCfg;
        // Force position always reads zero
        `SOLC_OFF_SEC_CTRL: state_nxt.rdData = state_r.secCtrl;
        `SOLC_OFF_SEC_STAT: state_nxt.rdData = statusWord;
        default: state_nxt.rdData = 8'h00;
      endcase
    end
    // Clear on status read first, then new events set: set wins
    if (regRead && regAddr == `SOLC_OFF_SEC_STAT)
      state_nxt.events = 4'h0;
    state_nxt.events = state_nxt.events | eventHits;
    // Interrupt follows latched flags, so it falls only after a status read or an enable change
    state_nxt.irq = |(state_nxt.events & enablesOf(state_nxt.secCtrl));
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state_r.clkRec <= `SOLC_RST_CLK_RECOVERY;
      state_r.txCfg1 <= `SOLC_RST_TX_CFG1;
      state_r.txCfg2 <= `SOLC_RST_TX_CFG2;
      state_r.rxCfg <= `SOLC_RST_RX_CFG;
      state_r.secCtrl <= `SOLC_RST_SEC_CTRL;
      state_r.stateSeen <= 3'b000;
      state_r.events <= 4'h0;
      state_r.rdData <= 8'h00;
      state_r.forceReq <= 1'b0;
      state_r.irq <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // ------------------------------------------------------------
  // Outputs, all straight from flip-flops
  // ------------------------------------------------------------
  assign regRdData = state_r.rdData;
  assign forceFrameLoss = state_r.forceReq;
  assign descrambleDisable = state_r.secCtrl[`SOLC_B_DDS];
  // Analog transmitter consumes these levels directly
  assign txDriveEnable = state_r.txCfg1[`SOLC_B_OE];
  assign txTrueQuiet = state_r.txCfg1[`SOLC_B_TQ];
  assign referenceSelect = state_r.txCfg1[`SOLC_B_VREF];
  // Reserved words pass to analog trim; software keeps defaults
  assign clockRecoveryCfg = state_r.clkRec;
  assign txCfgSecond = state_r.txCfg2;
  assign rxCfg = state_r.rxCfg;
  assign irqOut = state_r.irq;

  // ------------------------------------------------------------
  // Check helpers
  // ------------------------------------------------------------
  // Decoded bus strobes, shared by the checks below
  logic ctrlWrite;
  logic forceWrite;
  logic txWrite;
  logic statRead;
  assign ctrlWrite = regWrite && (regAddr == `SOLC_OFF_SEC_CTRL);
  assign forceWrite = ctrlWrite && regWrData[`SOLC_B_FORCE];
  assign txWrite = regWrite && (regAddr == `SOLC_OFF_TX_CFG1);
  assign statRead = regRead && (regAddr == `SOLC_OFF_SEC_STAT);

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_oofEvent;
    @(posedge clock) disable iff (rst)
      ($changed(frameOutState) && !$past(rst)) |=> state_r.events[0];
  endproperty
  a_oofEvent: assert property (p_oofEvent)
    else $error("out-of-frame change not latched");

  property p_lofEvent;
    @(posedge clock) disable iff (rst)
      ($changed(frameLossState) && !$past(rst)) |=> state_r.events[1];
  endproperty
  a_lofEvent: assert property (p_lofEvent)
    else $error("loss-of-frame change not latched");

  property p_losEvent;
    @(posedge clock) disable iff (rst)
      ($changed(signalLossState) && !$past(rst)) |=> state_r.events[2];
  endproperty
  a_losEvent: assert property (p_losEvent)
    else $error("loss-of-signal change not latched");

  property p_bipEvent;
    @(posedge clock) disable iff (rst)
      sectionParityErr |=> state_r.events[3];
  endproperty
  a_bipEvent: assert property (p_bipEvent)
    else $error("parity error not latched");

  property p_readClears;
    @(posedge clock) disable iff (rst)
      (regRead && regAddr == `SOLC_OFF_SEC_STAT && !sectionParityErr)
        |=> !state_r.events[3];
  endproperty
  a_readClears: assert property (p_readClears)
    else $error("status read did not clear parity flag");

  property p_statusLive;
    @(posedge clock) disable iff (rst)
      (regRead && regAddr == `SOLC_OFF_SEC_STAT)
        |=> regRdData[2:0] == $past(stateNow);
  endproperty
  a_statusLive: assert property (p_statusLive)
    else $error("status read shows wrong alarm state");

  property p_irqEnabled;
    @(posedge clock) disable iff (rst)
      irqOut == |(state_r.events & eventEnables);
  endproperty
  a_irqEnabled: assert property (p_irqEnabled)
    else $error("interrupt does not match enabled flags");

  property p_forceHold;
    @(posedge clock) disable iff (rst)
      (forceFrameLoss && !frameBoundary) |=> forceFrameLoss;
  endproperty
  a_forceHold: assert property (p_forceHold)
    else $error("force request dropped before frame boundary");

  property p_forceArm;
    @(posedge clock) disable iff (rst)
      (regWrite && regAddr == `SOLC_OFF_SEC_CTRL && regWrData[5])
        |=> forceFrameLoss;
  endproperty
  a_forceArm: assert property (p_forceArm)
    else $error("force write not armed");

  property p_coincident;
    @(posedge clock) disable iff (rst)
      (regRead && regAddr == `SOLC_OFF_SEC_STAT && sectionParityErr)
        |=> state_r.events[3] ##1 !(regRead && regAddr == 8'h11)
        [*1] |-> state_r.events[3];
  endproperty
  a_coincident: assert property (p_coincident)
    else $error("coincident event lost by clearing read");

  // Each enabled source raises the interrupt one cycle later
  property p_irqOof;
    @(posedge clock) disable iff (rst)
      ($changed(frameOutState) && !$past(rst) && !ctrlWrite &&
        eventEnables[`SOLC_B_OOF_EN]) |=> irqOut;
  endproperty
  a_irqOof: assert property (p_irqOof)
    else $error("out-of-frame change raised no interrupt");

  property p_irqLof;
    @(posedge clock) disable iff (rst)
      ($changed(frameLossState) && !$past(rst) && !ctrlWrite &&
        eventEnables[`SOLC_B_LOF_EN]) |=> irqOut;
  endproperty
  a_irqLof: assert property (p_irqLof)
    else $error("loss-of-frame change raised no interrupt");

  property p_irqLos;
    @(posedge clock) disable iff (rst)
      ($changed(signalLossState) && !$past(rst) && !ctrlWrite &&
        eventEnables[`SOLC_B_LOS_EN]) |=> irqOut;
  endproperty
  a_irqLos: assert property (p_irqLos)
    else $error("loss-of-signal change raised no interrupt");

  property p_irqBip;
    @(posedge clock) disable iff (rst)
      (sectionParityErr && !ctrlWrite && eventEnables[`SOLC_B_BIP_EN])
        |=> irqOut;
  endproperty
  a_irqBip: assert property (p_irqBip)
    else $error("parity error raised no interrupt");

  // Interrupt may only fall after a status read or an enable change
  property p_irqHeld;
    @(posedge clock) disable iff (rst)
      (irqOut && !statRead && !ctrlWrite)
        |=> irqOut;
  endproperty
  a_irqHeld: assert property (p_irqHeld)
    else $error("interrupt dropped with flags still set");

  // Software must not see the force bit stored
  property p_forceReadsZero;
    @(posedge clock) disable iff (rst)
      (regRead && regAddr == `SOLC_OFF_SEC_CTRL)
        |=> !regRdData[`SOLC_B_FORCE];
  endproperty
  a_forceReadsZero: assert property (p_forceReadsZero)
    else $error("force position read back as one");

  property p_forceDrop;
    @(posedge clock) disable iff (rst)
      (forceFrameLoss && frameBoundary && !forceWrite)
        |=> !forceFrameLoss;
  endproperty
  a_forceDrop: assert property (p_forceDrop)
    else $error("force request outlived its frame boundary");

  // Control levels follow the written word on the next cycle
  property p_descramble;
    @(posedge clock) disable iff (rst)
      ctrlWrite
        |=> descrambleDisable == $past(regWrData[`SOLC_B_DDS]);
  endproperty
  a_descramble: assert property (p_descramble)
    else $error("descramble control does not follow write");

  property p_txDrive;
    @(posedge clock) disable iff (rst)
      txWrite
        |=> txDriveEnable == $past(regWrData[`SOLC_B_OE]);
  endproperty
  a_txDrive: assert property (p_txDrive)
    else $error("transmit enable does not follow write");

  property p_trueQuiet;
    @(posedge clock) disable iff (rst)
      txWrite
        |=> txTrueQuiet == $past(regWrData[`SOLC_B_TQ]);
  endproperty
  a_trueQuiet: assert property (p_trueQuiet)
    else $error("true-quiet control does not follow write");

  property p_refSelect;
    @(posedge clock) disable iff (rst)
      txWrite
        |=> referenceSelect == $past(regWrData[`SOLC_B_VREF]);
  endproperty
  a_refSelect: assert property (p_refSelect)
    else $error("reference select does not follow write");

  // Alarm flags clear on a status read when no alarm moves
  property p_alarmClears;
    @(posedge clock) disable iff (rst)
      (statRead && $stable(stateNow) && !$past(rst))
        |=> state_r.events[2:0] == 3'b000;
  endproperty
  a_alarmClears: assert property (p_alarmClears)
    else $error("status read did not clear alarm flags");

  // Read data stand only in the cycle after a read strobe
  property p_rdIdle;
    @(posedge clock) disable iff (rst)
      !regRead
        |=> regRdData == 8'h00;
  endproperty
  a_rdIdle: assert property (p_rdIdle)
    else $error("read data present without a read");

  property p_cfgHold;
    @(posedge clock) disable iff (rst)
      !regWrite |=> $stable(clockRecoveryCfg) && $stable(txCfgSecond)
        && $stable(rxCfg);
  endproperty
  a_cfgHold: assert property (p_cfgHold)
    else $error("configuration word moved without a write");

endmodule

// >>> test/tb_section_overhead_line_config_regs.sv
// Self-checking bench for the section/line register bank
`timescale 1ns/10ps
`include "solc_defines.svh"
`define CHK(nm, e, g) begin numChecks++; if ((g) !== (e)) begin fails++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end

module tb_section_overhead_line_config_regs;
  logic clock, rst, regWrite, regRead, parErr, boundary;
  logic [7:0] regAddr, regWrData, regRdData, rdv, exp;
  logic [2:0] st;
  logic forceFrameLoss, descrambleDisable, txDriveEnable, txTrueQuiet;
  logic referenceSelect, irqOut;
  logic [7:0] clockRecoveryCfg, txCfgSecond, rxCfg;
  int fails = 0;
  int numChecks = 0;
  // Address, write data, read-back; reserved bits always written at
  // their defaults, unused bits set to show that they read zero
  logic [7:0] rows [0:7][0:2] = '{'{8'h09, 8'hff, 8'h07},
    '{8'h0a, 8'hac, 8'hac}, '{8'h0a, 8'h5c, 8'h1c}, '{8'h0b, 8'hff, 8'hff},
    '{8'h0c, 8'h81, 8'h01}, '{8'h10, 8'h6f, 8'h4f}, '{8'h20, 8'hff, 8'h00},
    '{8'h0d, 8'hff, 8'h00}};

  section_overhead_line_config_regs dut_u (.clock(clock), .rst(rst),
    .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
    .regRead(regRead), .regRdData(regRdData), .frameOutState(st[0]),
    .frameLossState(st[1]), .signalLossState(st[2]),
    .sectionParityErr(parErr), .frameBoundary(boundary),
    .forceFrameLoss(forceFrameLoss), .descrambleDisable(descrambleDisable),
    .txDriveEnable(txDriveEnable), .txTrueQuiet(txTrueQuiet),
    .referenceSelect(referenceSelect), .clockRecoveryCfg(clockRecoveryCfg),
    .txCfgSecond(txCfgSecond), .rxCfg(rxCfg), .irqOut(irqOut));

  // ----------------------------------------------------------------
  // Clock and bus tasks
  // ----------------------------------------------------------------
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Settle point: one ns past the edge so all updates have landed
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    #1 rdv = regRdData;
    `CHK("read data", e, rdv)
  endtask

  // Alarm levels move for good; parity is a one-cycle pulse
  task automatic ev(input int i, input logic v);
    @(posedge clock);
    if (i < 3)
      st[i] <= v;
    else
      parErr <= 1'b1;
    @(posedge clock);
    parErr <= 1'b0;
  endtask

  task give_verdict;
    $display("checks %0d mismatches %0d", numChecks, fails);
    if (fails == 0 && numChecks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    rst = 1'b1;
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
    st = 3'h0;
    parErr = 1'b0;
    boundary = 1'b0;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    for (int r = 0; r < 8; r++)
    begin
      wr(rows[r][0], rows[r][1]);
      rchk(rows[r][0], rows[r][2]);
    end
    $display("test table done");
    // Second reset in mid-run must restore every default
    @(posedge clock);
    rst <= 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    step(1);
    `CHK("drive enable", 1'b1, txDriveEnable)
    `CHK("recovery cfg", `SOLC_RST_CLK_RECOVERY, clockRecoveryCfg)
    `CHK("tx cfg two", `SOLC_RST_TX_CFG2, txCfgSecond)
    `CHK("rx cfg", `SOLC_RST_RX_CFG, rxCfg)
    rchk(`SOLC_OFF_TX_CFG1, `SOLC_RST_TX_CFG1);
    rchk(`SOLC_OFF_SEC_CTRL, `SOLC_RST_SEC_CTRL);
    rchk(`SOLC_OFF_SEC_STAT, 8'h00);
    $display("test reset done");
    wr(`SOLC_OFF_TX_CFG1, 8'h9c);
    step(1);
    `CHK("drive enable", 1'b0, txDriveEnable)
    `CHK("true quiet", 1'b1, txTrueQuiet)
    `CHK("reference", 1'b1, referenceSelect)
    wr(`SOLC_OFF_SEC_CTRL, 8'h40);
    step(1);
    `CHK("descramble off", 1'b1, descrambleDisable)
    wr(`SOLC_OFF_SEC_CTRL, 8'h20);
    step(1);
    `CHK("descramble on", 1'b0, descrambleDisable)
    `CHK("force", 1'b1, forceFrameLoss)
    step(3);
    `CHK("force held", 1'b1, forceFrameLoss)
    @(posedge clock);
    boundary <= 1'b1;
    @(posedge clock);
    boundary <= 1'b0;
    step(1);
    `CHK("force done", 1'b0, forceFrameLoss)
    $display("test outputs done");
    // Each source: masked, then enabled, then cleared by a read
    for (int i = 0; i < 4; i++)
    begin
      wr(`SOLC_OFF_SEC_CTRL, 8'h00);
      ev(i, 1'b1);
      step(2);
      `CHK("irq masked", 1'b0, irqOut)
      wr(`SOLC_OFF_SEC_CTRL, 8'h01 << i);
      step(2);
      `CHK("irq set", 1'b1, irqOut)
      exp = (i < 3) ? ((8'h01 << i) | (8'h08 << i)) : 8'h40;
      rchk(`SOLC_OFF_SEC_STAT, exp);
      step(2);
      `CHK("irq clear", 1'b0, irqOut)
      rchk(`SOLC_OFF_SEC_STAT, exp & 8'h07);
      if (i < 3)
      begin
        ev(i, 1'b0);
        step(2);
        `CHK("irq fall", 1'b1, irqOut)
        rchk(`SOLC_OFF_SEC_STAT, 8'h08 << i);
      end
    end
    $display("test events done");
    // Error arriving with the clearing read survives for the next one
    @(posedge clock);
    regAddr <= `SOLC_OFF_SEC_STAT;
    regRead <= 1'b1;
    parErr <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    parErr <= 1'b0;
    #1;
    `CHK("coincident read", 8'h00, regRdData)
    `CHK("irq kept", 1'b1, irqOut)
    rchk(`SOLC_OFF_SEC_STAT, 8'h40);
    $display("test coincident done");
    give_verdict();
  end

  // Watchdog far beyond the length of the whole run
  initial
  begin
    #500000;
    fails++;
    give_verdict();
  end
endmodule
